// ### rtl/mrs_param_slave.sv
`timescale 1ns/100ps
`default_nettype none
`include "mrs_defines.svh"

module mrs_param_slave
  import mrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire mrs_byte_t rx_data,
  input wire logic rx_valid,
  input wire logic rx_frame_end,
  output mrs_byte_t tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire mrs_byte_t station_id_setting,
  input wire logic address_offset_mode,
  input wire logic drive_busy,
  input wire logic write_protect,
  output mrs_word_t par_addr,
  input wire mrs_word_t par_rdata,
  input wire logic par_exists,
  input wire logic par_writable,
  output logic par_wr_en,
  output mrs_word_t par_wdata
);

  function automatic logic is_read_fc(input mrs_byte_t f);
    return (f == `MRS_FC_RD_HOLD) || (f == `MRS_FC_RD_INPUT);
  endfunction : is_read_fc

  function automatic mrs_word_t map_addr(input mrs_word_t a, input logic m);
    return m ? a + `MRS_ADDR_OFFSET : a;
  endfunction : map_addr

  // ========================================================================
  // State
  mrs_state_e state_reg, state_next;
  mrs_byte_t rx_buf_reg [0:40];
  mrs_byte_t rx_buf_next [0:40];
  mrs_word_t rd_val_reg [0:15];
  mrs_word_t rd_val_next [0:15];
  logic [5:0] rx_cnt_reg, rx_cnt_next;
  logic rx_ovf_reg, rx_ovf_next;
  logic [4:0] idx_reg, idx_next;
  logic [4:0] n_reg, n_next;
  logic [4:0] good_reg, good_next;
  logic [1:0] phase_reg, phase_next;
  logic exc_reg, exc_next;
  mrs_byte_t exc_code_reg, exc_code_next;
  logic [5:0] tx_idx_reg, tx_idx_next;
  logic tx_valid_reg, tx_valid_next;
  mrs_byte_t tx_data_reg, tx_data_next;
  mrs_word_t par_addr_reg, par_addr_next;
  logic par_wr_en_reg, par_wr_en_next;
  mrs_word_t par_wdata_reg, par_wdata_next;

  mrs_byte_t fn;
  mrs_word_t st_addr, qty;
  logic qty_ok;
  logic [5:0] resp_len, wr_pos;
  mrs_byte_t resp_byte;
  logic tx_load;
  logic rx_crc_en, tx_crc_en;
  mrs_word_t rx_crc, tx_crc;

  assign fn = rx_buf_reg[1];
  assign st_addr = {rx_buf_reg[2], rx_buf_reg[3]};
  assign qty = {rx_buf_reg[4], rx_buf_reg[5]};
  assign qty_ok = (qty != 16'h0000) && (qty <= `MRS_MAX_REGS);
  assign wr_pos = 6'h07 + {idx_reg, 1'b0};
  assign tx_load = (state_reg == ST_SEND) && (!tx_valid_reg || tx_ready);
  assign rx_crc_en = rx_valid && ((state_reg == ST_IDLE) ||
    ((state_reg == ST_RECV) && (rx_cnt_reg != `MRS_BUF_LEN)));
  assign tx_crc_en = tx_load && (tx_idx_reg < resp_len);

  // ========================================================================
  // CRC of the incoming frame and of the reply
  mrs_crc16 u_rx_crc (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(state_reg == ST_IDLE),
    .en(rx_crc_en),
    .data(rx_data),
    .crc(rx_crc)
  );

  mrs_crc16 u_tx_crc (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(state_reg != ST_SEND),
    .en(tx_crc_en),
    .data(resp_byte),
    .crc(tx_crc)
  );

  // ========================================================================
  // Reply byte selection
  always_comb
  begin
    if (exc_reg)
      resp_len = `MRS_EXC_LEN;
    else if (is_read_fc(fn))
      resp_len = `MRS_RD_HDR_LEN + {n_reg, 1'b0};
    else
      resp_len = `MRS_WR_RESP_LEN;
    resp_byte = tx_crc[7:0];
    if (tx_idx_reg == 6'h00)
      resp_byte = rx_buf_reg[0];
    else if (tx_idx_reg == 6'h01)
      resp_byte = exc_reg ? (fn | `MRS_FC_EXC_FLAG) : fn;
    else if (tx_idx_reg == 6'h02 && exc_reg)
      resp_byte = exc_code_reg;
    else if (tx_idx_reg == 6'h02 && is_read_fc(fn))
      resp_byte = {2'b00, n_reg, 1'b0};
    else if (tx_idx_reg < resp_len && is_read_fc(fn))
      resp_byte = tx_idx_reg[0] ?
        rd_val_reg[4'((tx_idx_reg - 6'h03) >> 1)][15:8] :
        rd_val_reg[4'((tx_idx_reg - 6'h03) >> 1)][7:0];
    else if (tx_idx_reg < resp_len)
      resp_byte = rx_buf_reg[tx_idx_reg];
    else if (tx_idx_reg != resp_len)
      resp_byte = tx_crc[15:8];
  end

  // ========================================================================
  // Controller
  always_comb
  begin
    state_next = state_reg;
    rx_buf_next = rx_buf_reg;
    rd_val_next = rd_val_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_ovf_next = rx_ovf_reg;
    idx_next = idx_reg;
    n_next = n_reg;
    good_next = good_reg;
    phase_next = phase_reg;
    exc_next = exc_reg;
    exc_code_next = exc_code_reg;
    tx_idx_next = tx_idx_reg;
    tx_valid_next = tx_valid_reg;
    tx_data_next = tx_data_reg;
    par_addr_next = par_addr_reg;
    par_wr_en_next = 1'b0;
    par_wdata_next = par_wdata_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (rx_valid)
        begin
          rx_buf_next[0] = rx_data;
          rx_cnt_next = 6'h01;
          rx_ovf_next = 1'b0;
          state_next = ST_RECV;
        end
      end
      ST_RECV:
      begin
        // Bytes past the buffer only mark the frame as bad.
        if (rx_valid && rx_cnt_reg == `MRS_BUF_LEN)
          rx_ovf_next = 1'b1;
        else if (rx_valid)
        begin
          rx_buf_next[rx_cnt_reg] = rx_data;
          rx_cnt_next = rx_cnt_reg + 6'h01;
        end
        if (rx_frame_end)
          state_next = ST_CHECK;
      end
      ST_CHECK:
      begin
        idx_next = 5'h00;
        phase_next = 2'h0;
        good_next = 5'h00;
        n_next = qty[4:0];
        exc_next = 1'b1;
        tx_idx_next = 6'h00;
        state_next = ST_SEND;
        exc_code_next = `MRS_EXC_FUNCTION;
        if (rx_ovf_reg || rx_cnt_reg < `MRS_MIN_FRAME || rx_crc != 16'h0000 ||
            rx_buf_reg[0] != station_id_setting)
        begin
          exc_next = 1'b0;
          state_next = ST_IDLE;
        end
        else if (is_read_fc(fn))
        begin
          if (!qty_ok || rx_cnt_reg != `MRS_FIXED_LEN)
            exc_code_next = `MRS_EXC_VALUE;
          else if (drive_busy)
            exc_code_next = `MRS_EXC_BUSY;
          else
          begin
            exc_next = 1'b0;
            state_next = ST_EXEC;
          end
        end
        else if (fn == `MRS_FC_WR_SINGLE || fn == `MRS_FC_WR_MULTI)
        begin
          if (fn == `MRS_FC_WR_SINGLE)
            n_next = 5'h01;
          if (fn == `MRS_FC_WR_SINGLE ? rx_cnt_reg != `MRS_FIXED_LEN :
              (!qty_ok || rx_buf_reg[6] != {qty[6:0], 1'b0} ||
               rx_cnt_reg != `MRS_MULTI_HDR + {qty[4:0], 1'b0}))
            exc_code_next = `MRS_EXC_VALUE;
          else if (drive_busy)
            exc_code_next = `MRS_EXC_BUSY;
          else if (write_protect)
            exc_code_next = `MRS_EXC_PROTECT;
          else
          begin
            exc_next = 1'b0;
            state_next = ST_EXEC;
          end
        end
      end
      ST_EXEC:
      begin
        // Each register takes three steps: address out, answer sampled,
        // then, on a write, the strobe with address and data still held.
        if (phase_reg == 2'h0)
        begin
          par_addr_next = map_addr(st_addr + {11'h000, idx_reg},
            address_offset_mode);
          par_wdata_next = (fn == `MRS_FC_WR_SINGLE) ? qty :
            {rx_buf_reg[wr_pos], rx_buf_reg[wr_pos + 6'h01]};
          phase_next = 2'h1;
        end
        else if (phase_reg == 2'h1)
        begin
          if (is_read_fc(fn))
          begin
            rd_val_next[idx_reg[3:0]] = par_exists ? par_rdata :
              `MRS_BAD_VALUE;
            good_next = good_reg + {4'h0, par_exists};
          end
          else
          begin
            par_wr_en_next = par_exists && par_writable;
            good_next = good_reg + {4'h0, par_exists && par_writable};
          end
          phase_next = 2'h2;
        end
        else if (idx_reg == n_reg - 5'h01)
        begin
          exc_next = (good_reg == 5'h00);
          exc_code_next = `MRS_EXC_ADDRESS;
          tx_idx_next = 6'h00;
          state_next = ST_SEND;
        end
        else
        begin
          idx_next = idx_reg + 5'h01;
          phase_next = 2'h0;
        end
      end
      ST_SEND:
      begin
        if (tx_load && tx_idx_reg == resp_len + 6'h02)
        begin
          tx_valid_next = 1'b0;
          state_next = ST_IDLE;
        end
        else if (tx_load)
        begin
          tx_data_next = resp_byte;
          tx_valid_next = 1'b1;
          tx_idx_next = tx_idx_reg + 6'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      for (int i = 0; i < 41; i++)
        rx_buf_reg[i] <= 8'h00;
      for (int i = 0; i < 16; i++)
        rd_val_reg[i] <= 16'h0000;
      rx_cnt_reg <= 6'h00;
      rx_ovf_reg <= 1'b0;
      idx_reg <= 5'h00;
      n_reg <= 5'h00;
      good_reg <= 5'h00;
      phase_reg <= 2'h0;
      exc_reg <= 1'b0;
      exc_code_reg <= 8'h00;
      tx_idx_reg <= 6'h00;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      par_addr_reg <= 16'h0000;
      par_wr_en_reg <= 1'b0;
      par_wdata_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      rx_buf_reg <= rx_buf_next;
      rd_val_reg <= rd_val_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_ovf_reg <= rx_ovf_next;
      idx_reg <= idx_next;
      n_reg <= n_next;
      good_reg <= good_next;
      phase_reg <= phase_next;
      exc_reg <= exc_next;
      exc_code_reg <= exc_code_next;
      tx_idx_reg <= tx_idx_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
      par_addr_reg <= par_addr_next;
      par_wr_en_reg <= par_wr_en_next;
      par_wdata_reg <= par_wdata_next;
    end
  end

  assign tx_data = tx_data_reg;
  assign tx_valid = tx_valid_reg;
  assign par_addr = par_addr_reg;
  assign par_wr_en = par_wr_en_reg;
  assign par_wdata = par_wdata_reg;

  // ========================================================================
  // Checks
  sequence s_check_reject;
    state_reg == ST_CHECK && (rx_crc != 16'h0000 ||
      rx_buf_reg[0] != station_id_setting);
  endsequence

  sequence s_tx_stall;
    tx_valid_reg && !tx_ready;
  endsequence

  a_reject_silent: assert property (@(posedge clk_sys)
    disable iff (rst)
    s_check_reject |=> state_reg == ST_IDLE ##1 !tx_valid_reg)
    else $error("rejected frame was answered");

  a_tx_hold_stable: assert property (@(posedge clk_sys)
    disable iff (rst)
    s_tx_stall |=> tx_valid_reg && $stable(tx_data_reg))
    else $error("reply byte changed while stalled");

  a_addr_offset_map: assert property (@(posedge clk_sys)
    disable iff (rst)
    state_reg == ST_EXEC && phase_reg == 2'h0 |=> par_addr_reg ==
      $past(st_addr) + {11'h000, $past(idx_reg)} +
      {15'h0000, $past(address_offset_mode)})
    else $error("parameter address offset wrong");

  a_read_bad_value: assert property (@(posedge clk_sys)
    disable iff (rst)
    state_reg == ST_EXEC && phase_reg == 2'h1 && is_read_fc(fn) &&
      !par_exists |=> rd_val_reg[$past(idx_reg[3:0])] == 16'hffff)
    else $error("missing parameter not read as FFFF");

  a_write_strobe_cause: assert property (@(posedge clk_sys)
    disable iff (rst)
    par_wr_en_reg |-> $past(par_exists && par_writable &&
      state_reg == ST_EXEC && phase_reg == 2'h1) &&
      $stable(par_addr_reg))
    else $error("write strobe without writable target");

  a_all_invalid_exc: assert property (@(posedge clk_sys)
    disable iff (rst)
    state_reg == ST_EXEC && phase_reg == 2'h2 && idx_reg == n_reg - 5'h01 &&
      good_reg == 5'h00 |=> exc_reg && exc_code_reg == 8'h02)
    else $error("all-invalid request not answered by exception");

  a_exc_func_byte: assert property (@(posedge clk_sys)
    disable iff (rst)
    tx_load && exc_reg && tx_idx_reg == 6'h01 |=>
      tx_data_reg == (rx_buf_reg[1] | 8'h80) && resp_len == 6'h03)
    else $error("exception function byte wrong");

  a_read_byte_count: assert property (@(posedge clk_sys)
    disable iff (rst)
    tx_load && !exc_reg && is_read_fc(fn) && tx_idx_reg == 6'h02 |=>
      tx_data_reg == {2'b00, n_reg, 1'b0})
    else $error("read byte count not twice the count");

endmodule : mrs_param_slave

`default_nettype wire

// ### rtl/mrs_defines.svh
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH

// ==========================================================================
// Function codes and exception codes
`define MRS_FC_RD_HOLD 8'h03
`define MRS_FC_RD_INPUT 8'h04
`define MRS_FC_WR_SINGLE 8'h06
`define MRS_FC_WR_MULTI 8'h10
`define MRS_FC_EXC_FLAG 8'h80
`define MRS_EXC_FUNCTION 8'h01
`define MRS_EXC_ADDRESS 8'h02
`define MRS_EXC_VALUE 8'h03
`define MRS_EXC_BUSY 8'h06
`define MRS_EXC_PROTECT 8'h14

// ==========================================================================
// Frame layout and limits
`define MRS_MAX_REGS 16'h0010
`define MRS_BUF_LEN 6'h29
`define MRS_MIN_FRAME 6'h04
`define MRS_FIXED_LEN 6'h08
`define MRS_MULTI_HDR 6'h09
`define MRS_EXC_LEN 6'h03
`define MRS_WR_RESP_LEN 6'h06
`define MRS_RD_HDR_LEN 6'h03
`define MRS_BAD_VALUE 16'hffff
`define MRS_ADDR_OFFSET 16'h0001

// ==========================================================================
// CRC-16 constants
`define MRS_CRC_INIT 16'hffff
`define MRS_CRC_POLY 16'ha001

`endif

// ### rtl/mrs_pkg.sv
package mrs_pkg;

  // ========================================================================
  // Controller states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RECV = 5'b00010,
    ST_CHECK = 5'b00100,
    ST_EXEC = 5'b01000,
    ST_SEND = 5'b10000
  } mrs_state_e;

  typedef logic [7:0] mrs_byte_t;
  typedef logic [15:0] mrs_word_t;

endpackage : mrs_pkg

// ### rtl/mrs_crc16.sv
`timescale 1ns/100ps
`default_nettype none
`include "mrs_defines.svh"

module mrs_crc16
  import mrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  input wire mrs_byte_t data,
  output var mrs_word_t crc
);

  function automatic mrs_word_t crc_byte(input mrs_word_t c,
    input mrs_byte_t d);
    mrs_word_t r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  mrs_word_t crc_reg;
  mrs_word_t crc_next;
  mrs_word_t base;

  // A clear together with a byte starts a new sum with that byte.
  always_comb
  begin
    base = clr ? `MRS_CRC_INIT : crc_reg;
    crc_next = en ? crc_byte(base, data) : base;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      crc_reg <= `MRS_CRC_INIT;
    else
      crc_reg <= crc_next;
  end

  assign crc = crc_reg;

endmodule : mrs_crc16

`default_nettype wire

// ### tb/mrs_param_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Drive parameter space behind the interpreter
module mrs_param_model
  import mrs_pkg::*;
#(
  parameter mrs_word_t BASE = 16'h1200,
  parameter int COUNT = 6
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire mrs_word_t par_addr,
  output mrs_word_t par_rdata,
  output logic par_exists,
  output logic par_writable,
  input wire logic par_wr_en,
  input wire mrs_word_t par_wdata
);
  mrs_word_t mem_reg [COUNT];
  int idx;

  assign idx = int'(par_addr - BASE);
  assign par_exists = (par_addr >= BASE) && (idx < COUNT);
  // The first location is read-only so that skipped writes can be seen.
  assign par_writable = par_exists && (idx != 0);
  // Absent places return a pattern that moves with the address, not a
  // stale value that a sloppy design could pass on by luck.
  assign par_rdata = par_exists ? mem_reg[idx] : (par_addr ^ 16'h5555);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < COUNT; i++)
      begin
        mem_reg[i] <= 16'h5a00 | 16'(i);
      end
    end
    else if (par_wr_en && par_writable)
    begin
      mem_reg[idx] <= par_wdata;
    end
  end
endmodule : mrs_param_model

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "mrs_defines.svh"

module testbench
  import mrs_pkg::*;
;
  localparam mrs_byte_t SID = 8'h2c;
  logic clk_sys, rst, rx_valid, rx_frame_end, tx_valid, tx_ready;
  logic address_offset_mode, drive_busy, write_protect;
  logic par_exists, par_writable, par_wr_en;
  mrs_byte_t rx_data, tx_data, station_id_setting;
  mrs_word_t par_addr, par_rdata, par_wdata;
  mrs_word_t shadow [6];
  mrs_byte_t none[$];
  int n_errors, n_compared;

  mrs_param_slave mrs_param_slave_i (.clk_sys(clk_sys), .rst(rst),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_frame_end(rx_frame_end),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .station_id_setting(station_id_setting),
    .address_offset_mode(address_offset_mode), .drive_busy(drive_busy),
    .write_protect(write_protect), .par_addr(par_addr),
    .par_rdata(par_rdata), .par_exists(par_exists),
    .par_writable(par_writable), .par_wr_en(par_wr_en),
    .par_wdata(par_wdata));

  mrs_param_model mrs_param_model_i (.clk_sys(clk_sys), .rst(rst),
    .par_addr(par_addr), .par_rdata(par_rdata), .par_exists(par_exists),
    .par_writable(par_writable), .par_wr_en(par_wr_en),
    .par_wdata(par_wdata));

  // ========================================================================
  // Helpers
  function automatic mrs_word_t crc16(input mrs_byte_t q[$]);
    mrs_word_t c;
    c = `MRS_CRC_INIT;
    foreach (q[i])
    begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ `MRS_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16

  function automatic mrs_word_t exp_par(input mrs_word_t a);
    return (a >= 16'h1200 && a < 16'h1206) ? shadow[a[2:0]] : `MRS_BAD_VALUE;
  endfunction : exp_par

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Sends one frame with its check word, then collects the reply while the
  // sink stalls every other cycle. An empty expectation means silence.
  task automatic xfer(input mrs_byte_t req[$], input mrs_byte_t exp[$],
                      input bit bad);
    mrs_word_t c;
    mrs_byte_t got[$];
    int k;
    c = crc16(req);
    req.push_back(c[7:0] ^ {7'h00, bad});
    req.push_back(c[15:8]);
    foreach (req[i])
    begin
      @(posedge clk_sys);
      rx_data <= req[i];
      rx_valid <= 1'b1;
      rx_frame_end <= (i == req.size() - 1);
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_frame_end <= 1'b0;
    if (exp.size() > 0)
    begin
      c = crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    k = 0;
    while (k < 400 && got.size() < exp.size())
    begin
      @(posedge clk_sys);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
        got.push_back(tx_data);
      // Ready drops once the whole reply is in or the wait runs out.
      tx_ready <= (got.size() < exp.size() && k < 399) ? ~tx_ready : 1'b0;
      k++;
    end
    check("reply length", 16'(got.size()), 16'(exp.size()));
    foreach (got[i])
      check("reply byte", {8'h00, got[i]}, {8'h00, exp[i]});
    repeat (40) @(posedge clk_sys);
    check("link idle", {15'h0, tx_valid}, 16'h0000);
  endtask : xfer

  task automatic rd(input bit mode, input mrs_byte_t fc,
                    input mrs_word_t bus, input int n);
    mrs_byte_t req[$];
    mrs_byte_t exp[$];
    mrs_word_t w;
    req = '{SID, fc, bus[15:8], bus[7:0], 8'h00, 8'(n)};
    exp = '{SID, fc, 8'(2 * n)};
    for (int j = 0; j < n; j++)
    begin
      w = exp_par(bus + 16'(mode) + 16'(j));
      exp.push_back(w[15:8]);
      exp.push_back(w[7:0]);
    end
    address_offset_mode <= mode;
    xfer(req, exp, 1'b0);
  endtask : rd

  task automatic exc(input bit busy, input bit prot, input mrs_byte_t q[$],
                     input mrs_byte_t code);
    mrs_byte_t exp[$];
    exp = '{SID, q[0] | `MRS_FC_EXC_FLAG, code};
    q.push_front(SID);
    drive_busy <= busy;
    write_protect <= prot;
    xfer(q, exp, 1'b0);
  endtask : exc

  // ========================================================================
  // Scenarios
  task automatic t_read();
    rd(1'b1, `MRS_FC_RD_HOLD, 16'h1203, 4);
    rd(1'b0, `MRS_FC_RD_INPUT, 16'h1200, 1);
    rd(1'b1, `MRS_FC_RD_HOLD, 16'h11ff, 16);
    $display("test read done");
  endtask : t_read

  task automatic t_write_single();
    mrs_byte_t req[$];
    req = '{SID, `MRS_FC_WR_SINGLE, 8'h12, 8'h02, 8'hab, 8'hcd};
    shadow[3] = 16'habcd;
    xfer(req, req, 1'b0);
    rd(1'b1, `MRS_FC_RD_HOLD, 16'h1202, 1);
    $display("test write single done");
  endtask : t_write_single

  task automatic t_write_multi();
    mrs_byte_t req[$];
    mrs_byte_t exp[$];
    exp = '{SID, `MRS_FC_WR_MULTI, 8'h11, 8'hff, 8'h00, 8'h03};
    req = '{SID, `MRS_FC_WR_MULTI, 8'h11, 8'hff, 8'h00, 8'h03, 8'h06,
            8'h0f, 8'h01, 8'h0f, 8'h02, 8'h0f, 8'h03};
    shadow[1] = 16'h0f02;
    shadow[2] = 16'h0f03;
    xfer(req, exp, 1'b0);
    rd(1'b1, `MRS_FC_RD_HOLD, 16'h11ff, 3);
    $display("test write multi done");
  endtask : t_write_multi

  task automatic t_exceptions();
    exc(0, 0, '{8'h05, 8'h12, 8'h00, 8'h00, 8'h01},
        `MRS_EXC_FUNCTION);
    exc(0, 0, '{8'h03, 8'h12, 8'h00, 8'h00, 8'h00}, `MRS_EXC_VALUE);
    exc(0, 0, '{8'h04, 8'h12, 8'h00, 8'h00, 8'h11}, `MRS_EXC_VALUE);
    exc(0, 0, '{8'h03, 8'h20, 8'h00, 8'h00, 8'h02}, `MRS_EXC_ADDRESS);
    exc(0, 0, '{8'h10, 8'h30, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34},
        `MRS_EXC_ADDRESS);
    exc(0, 0, '{8'h06, 8'h11, 8'hff, 8'h12, 8'h34},
        `MRS_EXC_ADDRESS);
    exc(1, 0, '{8'h03, 8'h12, 8'h00, 8'h00, 8'h01}, `MRS_EXC_BUSY);
    exc(0, 1, '{8'h06, 8'h12, 8'h01, 8'h12, 8'h34},
        `MRS_EXC_PROTECT);
    drive_busy <= 1'b0;
    write_protect <= 1'b0;
    $display("test exceptions done");
  endtask : t_exceptions

  task automatic t_silent();
    mrs_byte_t req[$];
    req = '{SID + 8'h01, `MRS_FC_RD_HOLD, 8'h12, 8'h00, 8'h00, 8'h01};
    xfer(req, none, 1'b0);
    req = '{SID, `MRS_FC_WR_SINGLE, 8'h12, 8'h02, 8'h55, 8'h55};
    xfer(req, none, 1'b1);
    rd(1'b1, `MRS_FC_RD_HOLD, 16'h1202, 1);
    $display("test silent done");
  endtask : t_silent

  // ========================================================================
  // Clock, reset, sequence and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    for (int i = 0; i < 6; i++)
      shadow[i] = 16'h5a00 | 16'(i);
    rst = 1'b1;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b0;
    station_id_setting = SID;
    address_offset_mode = 1'b1;
    drive_busy = 1'b0;
    write_protect = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_read();
    t_write_single();
    t_write_multi();
    t_exceptions();
    t_silent();
    end_sim();
  end

  // About twenty frames of under two hundred cycles each fit well inside this.
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    n_errors++;
    end_sim();
  end
endmodule : testbench

`default_nettype wire
